// ---- period_match_timer_8bit_bench.sv ----
// Self-checking bench for the period match timer over AXI4-Lite.
// Assumes pmt_pkg and pmt_timer are compiled first; one 10 MHz clock.
`timescale 1ns/1ps
module period_match_timer_8bit_bench
  import pmt_pkg::*;
;
  logic              clock;
  logic              rst;
  logic [ADDR_W-1:0] awa;
  logic [ADDR_W-1:0] ara;
  logic [DATA_W-1:0] wd;
  logic [DATA_W-1:0] rdat;
  logic [3:0]        ws;
  logic [1:0]        bresp;
  logic [1:0]        rresp;
  logic              awv, wv, bry, arv, rry;
  logic              awrdy, wrdy, bv, ardy, rv;
  logic              irq, tick, pwm;
  logic [7:0]        v;
  logic [33:0]       rd_q[$];
  logic [1:0]        wr_q[$];
  int                fails = 0;
  int                checked = 0;
  int                cyc = 0;
  int                n;

  pmt_timer dut (
    .clock(clock), .rst(rst),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awrdy),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
    .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(ardy), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rry), .irq(irq),
    .match_tick(tick), .pwm_time_base(pwm)
  );

  initial clock = 1'b0;
  always #50 clock = ~clock;

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    if (fails == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] r = RESP_OKAY,
                     input logic [3:0] s = 4'hF);
    wr_q.push_back(r);
    awa <= a;
    wd <= 32'(d);
    ws <= s;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do
    begin
      @(posedge clock);
      if (awrdy) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
    end
    while (bv !== 1'b1);
    // Extra edge so bready never toggles twice in one step
    bry <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rdd(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] r = RESP_OKAY);
    rd_q.push_back({r, 32'(d)});
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do
    begin
      @(posedge clock);
      if (ardy) arv <= 1'b0;
    end
    while (rv !== 1'b1);
    rry <= 1'b0;
    @(posedge clock);
  endtask

  task automatic gap(output int g);
    g = 0;
    do
    begin
      @(posedge clock);
      g++;
    end
    while (tick !== 1'b1 && g < 5000);
  endtask

  // Sample the level away from the edge that may move it
  task automatic chk_irq(input logic e);
    @(negedge clock);
    chk(34'(irq), 34'(e));
    @(posedge clock);
  endtask

  always @(posedge clock)
  begin
    if (bv && bry) chk(34'(bresp), 34'(wr_q.pop_front()));
    if (rv && rry) chk({rresp, rdat}, rd_q.pop_front());
    if (tick === 1'b1 || pwm === 1'b1)
      chk(34'({pwm, tick}), 34'h0_0000_0003);
    cyc++;
    if (cyc > 20000)
    begin
      fails++;
      test_done();
    end
  end

  initial
  begin
    rst = 1'b1;
    awv = 1'b0;
    wv = 1'b0;
    bry = 1'b0;
    arv = 1'b0;
    rry = 1'b0;
    awa = '0;
    ara = '0;
    wd = '0;
    ws = '0;
    void'($urandom(32'hefd0_979b));
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rdd(OFF_CONTROL, 8'h00);
    rdd(OFF_COUNT, COUNT_RESET);
    rdd(OFF_PERIOD, PERIOD_RESET);
    rdd(OFF_FLAG, 8'h00);
    rdd(OFF_ENABLE, 8'h00);
    repeat (4)
    begin
      v = 8'($urandom);
      wrr(OFF_PERIOD, v);
      rdd(OFF_PERIOD, v);
      wrr(OFF_COUNT, ~v);
      rdd(OFF_COUNT, ~v);
    end
    wrr(OFF_PERIOD, 8'h5A, RESP_OKAY, 4'h0);
    rdd(OFF_PERIOD, v);
    wrr(OFF_CONTROL, 8'hF8);
    rdd(OFF_CONTROL, 8'h78);
    wrr(8'h14, 8'h01, RESP_SLVERR);
    rdd(8'h14, 8'h00, RESP_SLVERR);
    // Stopped count holds; control write leaves it alone
    wrr(OFF_COUNT, 8'h35);
    repeat (40) @(posedge clock);
    rdd(OFF_COUNT, 8'h35);
    // Started at divide by 16, so no tick lands before the read
    wrr(OFF_CONTROL, 8'h07);
    rdd(OFF_COUNT, 8'h35);
    wrr(OFF_PERIOD, 8'h02);
    wrr(OFF_COUNT, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      wrr(OFF_CONTROL, 8'(4 + s));
      gap(n);
      gap(n);
      chk(34'(n), 34'(12 * (s == 0 ? 1 : s == 1 ? 4 : 16)));
    end
    wrr(OFF_CONTROL, 8'h04);
    gap(n);
    gap(n);
    chk_irq(1'b0);
    wrr(OFF_ENABLE, 8'h02);
    chk_irq(1'b1);
    wrr(OFF_CONTROL, 8'h00);
    wrr(OFF_FLAG, 8'h00);
    rdd(OFF_FLAG, 8'h02);
    wrr(OFF_FLAG, 8'h02);
    rdd(OFF_FLAG, 8'h00);
    chk_irq(1'b0);
    // Matches counted from a cleared postscaler up to the flag
    wrr(OFF_PERIOD, 8'h01);
    for (int k = 0; k < 16; k++)
    begin
      wrr(OFF_CONTROL, 8'h00);
      wrr(OFF_FLAG, 8'h02);
      wrr(OFF_COUNT, 8'h00);
      wrr(OFF_CONTROL, 8'(k * 8 + 4));
      n = 0;
      for (int c = 0; c < 400 && irq !== 1'b1; c++)
      begin
        @(posedge clock);
        if (tick === 1'b1) n++;
      end
      chk(34'(n), 34'(k + 1));
    end
    test_done();
  end
endmodule // period_match_timer_8bit_bench

// ---- pmt_pkg.sv ----
// Constants, register map and field layout of the period match timer.
// Assumes a 32-bit AXI4-Lite master and one clock at oscillator rate.
package pmt_pkg;

  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;

  localparam logic [7:0]  OFF_CONTROL   = 8'h00;
  localparam logic [7:0]  OFF_COUNT     = 8'h04;
  localparam logic [7:0]  OFF_PERIOD    = 8'h08;
  localparam logic [7:0]  OFF_FLAG      = 8'h0C;
  localparam logic [7:0]  OFF_ENABLE    = 8'h10;

  localparam logic [7:0]  COUNT_RESET   = 8'h00;
  localparam logic [7:0]  PERIOD_RESET  = 8'hFF;
  localparam logic [6:0]  CONTROL_RESET = 7'h00;

  localparam int          FLAG_BIT      = 1;
  localparam int          CTL_RUN_BIT   = 2;

  // Instruction clock is one quarter of the oscillator
  localparam logic [1:0]  PHASE_LAST    = 2'h3;

  localparam logic [3:0]  PRE_TERM_1    = 4'h0;
  localparam logic [3:0]  PRE_TERM_4    = 4'h3;
  localparam logic [3:0]  PRE_TERM_16   = 4'hF;

  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_CONTROL,
    SEL_COUNT,
    SEL_PERIOD,
    SEL_FLAG,
    SEL_ENABLE
  } pmt_sel_e;

  typedef struct packed {
    logic [3:0] post_sel;
    logic       run;
    logic [1:0] pre_sel;
  } pmt_ctl_s;

endpackage

// ---- pmt_timer.sv ----
// Period match timer with an AXI4-Lite register slave.
// Assumes clock is the oscillator; one write and one read at a time.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module pmt_timer
  import pmt_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   irq,
  output logic                   match_tick,
  output logic                   pwm_time_base
);

  function automatic pmt_sel_e decode(input logic [ADDR_W-1:0] a);
    unique case (a)
      OFF_CONTROL: decode = SEL_CONTROL;
      OFF_COUNT:   decode = SEL_COUNT;
      OFF_PERIOD:  decode = SEL_PERIOD;
      OFF_FLAG:    decode = SEL_FLAG;
      OFF_ENABLE:  decode = SEL_ENABLE;
      default:     decode = SEL_NONE;
    endcase
  endfunction

  function automatic logic [3:0] pre_term(input logic [1:0] s);
    pre_term = s[1] ? PRE_TERM_16 : (s[0] ? PRE_TERM_4 : PRE_TERM_1);
  endfunction

  pmt_ctl_s              ctl_reg;
  logic [7:0]            count_reg;
  logic [7:0]            period_reg;
  logic                  flag_reg;
  logic                  enable_reg;
  logic [1:0]            phase_reg;
  logic [3:0]            pre_reg;
  logic [3:0]            post_reg;
  logic                  match_reg;
  logic [ADDR_W-1:0]     awaddr_reg;
  logic                  aw_full_reg;
  logic [DATA_W-1:0]     wdata_reg;
  logic [3:0]            wstrb_reg;
  logic                  w_full_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;
  logic                  rvalid_reg;
  logic [1:0]            rresp_reg;
  logic [DATA_W-1:0]     rdata_reg;

  logic                  wr_go;
  logic                  wr_lane;
  pmt_sel_e              wr_sel;
  logic                  wr_ctl;
  logic                  wr_cnt;
  logic                  wr_per;
  logic                  wr_flag;
  logic                  wr_en;
  logic                  instr_tick;
  logic                  timer_tick;
  logic                  match_hit;
  logic                  post_term;
  logic                  rd_go;
  logic [7:0]            rd_next;
  logic                  flag_next;

  // Write channel: address and data taken in either order
  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign wr_go   = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_sel  = decode(awaddr_reg);
  // Registers live in byte lane 0 only
  assign wr_lane = wr_go && wstrb_reg[0];
  assign wr_ctl  = wr_lane && (wr_sel == SEL_CONTROL);
  assign wr_cnt  = wr_lane && (wr_sel == SEL_COUNT);
  assign wr_per  = wr_lane && (wr_sel == SEL_PERIOD);
  assign wr_flag = wr_lane && (wr_sel == SEL_FLAG);
  assign wr_en   = wr_lane && (wr_sel == SEL_ENABLE);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      aw_full_reg <= 1'b0;
      awaddr_reg  <= '0;
    end
    else if (s_axi_awvalid && !aw_full_reg)
    begin
      aw_full_reg <= 1'b1;
      awaddr_reg  <= s_axi_awaddr;
    end
    else if (wr_go)
      aw_full_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      w_full_reg <= 1'b0;
      wdata_reg  <= '0;
      wstrb_reg  <= '0;
    end
    else if (s_axi_wvalid && !w_full_reg)
    begin
      w_full_reg <= 1'b1;
      wdata_reg  <= s_axi_wdata;
      wstrb_reg  <= s_axi_wstrb;
    end
    else if (wr_go)
      w_full_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  // Read channel: one cycle from address to data
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign rd_go = s_axi_arvalid && !rvalid_reg;

  always_comb
  begin
    rd_next = 8'h00;
    unique case (decode(s_axi_araddr))
      SEL_CONTROL: rd_next = {1'b0, ctl_reg};
      SEL_COUNT:   rd_next = count_reg;
      SEL_PERIOD:  rd_next = period_reg;
      SEL_FLAG:    rd_next[FLAG_BIT] = flag_reg;
      SEL_ENABLE:  rd_next[FLAG_BIT] = enable_reg;
      SEL_NONE:    rd_next = 8'h00;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= RESP_OKAY;
      rdata_reg  <= '0;
    end
    else if (rd_go)
    begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= {24'h00_0000, rd_next};
      rresp_reg  <= (decode(s_axi_araddr) == SEL_NONE) ? RESP_SLVERR
                                                       : RESP_OKAY;
    end
    else if (s_axi_rready)
      rvalid_reg <= 1'b0;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      ctl_reg <= CONTROL_RESET;
    else if (wr_ctl)
      ctl_reg <= wdata_reg[6:0];
  end

  // Instruction clock phase; frozen while stopped to save power
  always_ff @(posedge clock)
  begin
    if (rst)
      phase_reg <= 2'h0;
    else if (ctl_reg.run)
      phase_reg <= phase_reg + 2'h1;
  end

  // Tick suppressed on a control write so the count cannot move
  assign instr_tick = ctl_reg.run && (phase_reg == PHASE_LAST) &&
                      !wr_ctl && !wr_cnt;
  assign timer_tick = instr_tick && (pre_reg == pre_term(ctl_reg.pre_sel));
  assign match_hit  = timer_tick && (count_reg == period_reg);
  assign post_term  = match_hit && (post_reg == ctl_reg.post_sel);

  always_ff @(posedge clock)
  begin
    if (rst || wr_ctl || wr_cnt)
      pre_reg <= 4'h0;
    else if (instr_tick)
      pre_reg <= (pre_reg == pre_term(ctl_reg.pre_sel)) ? 4'h0
                                                        : pre_reg + 4'h1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      count_reg <= COUNT_RESET;
    else if (wr_cnt)
      count_reg <= wdata_reg[7:0];
    else if (match_hit)
      count_reg <= COUNT_RESET;
    else if (timer_tick)
      count_reg <= count_reg + 8'h01;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      period_reg <= PERIOD_RESET;
    else if (wr_per)
      period_reg <= wdata_reg[7:0];
  end

  always_ff @(posedge clock)
  begin
    if (rst || wr_ctl || wr_cnt)
      post_reg <= 4'h0;
    else if (match_hit)
      post_reg <= (post_reg == ctl_reg.post_sel) ? 4'h0 : post_reg + 4'h1;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      match_reg <= 1'b0;
    else
      match_reg <= match_hit;
  end

  assign match_tick    = match_reg;
  assign pwm_time_base = match_reg;

  // Set beats a write-one-to-clear in the same cycle
  assign flag_next = (flag_reg && !(wr_flag && wdata_reg[FLAG_BIT])) ||
                     post_term;

  always_ff @(posedge clock)
  begin
    if (rst)
      flag_reg <= 1'b0;
    else
      flag_reg <= flag_next;
  end

  always_ff @(posedge clock)
  begin
    if (rst)
      enable_reg <= 1'b0;
    else if (wr_en)
      enable_reg <= wdata_reg[FLAG_BIT];
  end

  assign irq = flag_reg && enable_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  match_clear_a: assert property (match_hit |=> count_reg == 8'h00)
    else $error("count not cleared after match");
  count_step_a: assert property (timer_tick && !match_hit |=>
      count_reg == $past(count_reg) + 8'h01)
    else $error("count did not step");
  stop_hold_a: assert property (!ctl_reg.run &&
      !wr_cnt && !wr_ctl |=>
      $stable(count_reg) && $stable(pre_reg) && $stable(post_reg))
    else $error("stopped timer moved");
  ctl_keeps_a: assert property (wr_ctl |=> $stable(count_reg))
    else $error("control write changed count");
  scaler_clear_a: assert property (wr_ctl || wr_cnt |=>
      pre_reg == 4'h0 && post_reg == 4'h0)
    else $error("scalers not cleared");
  reset_value_a: assert property ($past(rst) |->
      count_reg == 8'h00 && period_reg == 8'hFF)
    else $error("bad reset values");
  period_wr_a: assert property (wr_per |=>
      period_reg == $past(wdata_reg[7:0]))
    else $error("period write lost");
  div_one_a: assert property (ctl_reg.pre_sel == 2'b00 &&
      instr_tick |-> timer_tick)
    else $error("prescale 1 skipped tick");
  post_one_a: assert property (match_hit &&
      ctl_reg.post_sel == 4'h0 |=> flag_reg)
    else $error("1:1 postscale no flag");
  flag_irq_a: assert property (post_term && enable_reg && !wr_en |=>
      irq ##1 (flag_reg || $past(wr_flag)))
    else $error("flag or irq missing");
  no_enable_a: assert property (!enable_reg |-> !irq)
    else $error("irq while disabled");
  match_out_a: assert property (match_hit |=>
      match_tick && pwm_time_base ##1 !match_tick)
    else $error("match output pulse wrong");
  ctl_top_a: assert property (rd_go &&
      decode(s_axi_araddr) == SEL_CONTROL |=> s_axi_rdata[7] == 1'b0)
    else $error("control bit 7 not zero");
  on_run_a: assert property (ctl_reg.run &&
      phase_reg == PHASE_LAST && !wr_ctl && !wr_cnt &&
      ctl_reg.pre_sel == 2'b00 && count_reg != period_reg |=>
      count_reg == $past(count_reg) + 8'h01)
    else $error("running timer missed tick");
  equal_match_a: assert property (timer_tick &&
      count_reg == period_reg |-> ##1 match_reg)
    else $error("equal values gave no match");
  unscaled_a: assert property (match_hit |=> pwm_time_base)
    else $error("time base not unscaled");

  // Scaler limits, flag life and bus answers
  pre_range_a: assert property (ctl_reg.pre_sel == 2'b01 |->
      pre_reg <= PRE_TERM_4)
    else $error("prescaler passed divide by 4 limit");
  post_range_a: assert property (post_reg <= ctl_reg.post_sel)
    else $error("postscaler passed its select");
  flag_set_a: assert property (post_term |=> flag_reg)
    else $error("terminal count did not set flag");
  flag_clear_a: assert property (wr_flag && wdata_reg[FLAG_BIT] &&
      !post_term |=> !flag_reg)
    else $error("flag not cleared by write of one");
  flag_hold_a: assert property (flag_reg && !wr_flag |=> flag_reg)
    else $error("flag dropped without a write");
  flag_source_a: assert property (!flag_reg && !post_term |=>
      !flag_reg)
    else $error("flag set without terminal count");
  count_write_a: assert property (wr_cnt |=>
      count_reg == $past(wdata_reg[7:0]))
    else $error("count write lost");
  enable_write_a: assert property (wr_en |=>
      enable_reg == $past(wdata_reg[FLAG_BIT]))
    else $error("enable write lost");
  irq_level_a: assert property (flag_reg && enable_reg |-> irq)
    else $error("enabled flag gave no irq");
  count_hold_a: assert property (!timer_tick && !wr_cnt |=>
      $stable(count_reg))
    else $error("count moved without a tick");
  match_source_a: assert property (match_tick |->
      $past(match_hit))
    else $error("match pulse without a match");
  phase_stop_a: assert property (!ctl_reg.run |=>
      $stable(phase_reg))
    else $error("phase moved while stopped");
  write_okay_a: assert property (wr_go && wr_sel != SEL_NONE |=>
      s_axi_bvalid && s_axi_bresp == RESP_OKAY)
    else $error("mapped write not answered okay");
  write_error_a: assert property (wr_go && wr_sel == SEL_NONE |=>
      s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");
  read_valid_a: assert property (rd_go |=> s_axi_rvalid)
    else $error("read not answered");
  read_error_a: assert property (rd_go &&
      decode(s_axi_araddr) == SEL_NONE |=> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");

endmodule // pmt_timer
